// [design/twsea_core.sv]
// Function
// [RULE1] flag clear reports no-information status
// [RULE2] bus error reports bus-error status
// [RULE3] misplaced start or stop is bus error
// [RULE4] bus error sets transfer-done flag
// [RULE5] software recovers with stop plus flag write
// [RULE6] recovery: not-addressed slave, clear stop only
// [RULE7] recovery releases lines, sends no stop
// [RULE8] no-information status: wait or continue
// [RULE9] repeated start keeps bus ownership
// [RULE10] software uses repeated start for direction change
// [RULE11] identical masters see no contention
// [RULE12] driving one against zero loses arbitration
// [RULE13] loss in data: slave or wait
// [RULE14] loss in address: switch to slave check
// [RULE15] addressed former master enters receive/transmit
// [RULE16] unaddressed former master: slave or wait
// [RULE17] ack-enable low ignores own address
// [RULE18] compare driven and sampled sda
// [RULE19] after loss release sda for byte
`timescale 1ns/100ps
`default_nettype none
module twsea_core
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic link_clk,
	input wire logic sda_in,
	input wire logic [6:0] own_addr,
	input wire twsea_pkg::twsea_ctrl_t ctrl,
	input wire logic tx_bit_req,
	input wire logic tx_bit,
	output logic sda_out,
	output logic sda_oe_n,
	output logic scl_oe_n,
	output logic transfer_done_flag,
	output logic stop_request_bit,
	output logic [7:0] bus_status_register,
	output logic in_master,
	output logic start_pending
);

	logic bit_tgl;
	logic bit_val;
	logic start_tgl;
	logic stop_tgl;

	twsea_link u_link
	(
		.link_clk(link_clk),
		.rst_n(rst_n),
		.sda_in(sda_in),
		.bit_tgl(bit_tgl),
		.bit_val(bit_val),
		.start_tgl(start_tgl),
		.stop_tgl(stop_tgl)
	);

	typedef struct packed {
		logic [2:0] bit_s;
		logic [2:0] start_s;
		logic [2:0] stop_s;
		logic [1:0] val_s;
		twsea_pkg::twsea_mode_t mode;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic in_addr;
		logic lost;
		logic drive_low;
		logic flag;
		logic stop_rq;
		logic [7:0] status;
		logic owner;
		logic pend_start;
	} twsea_core_st_t;

	twsea_core_st_t st;
	twsea_core_st_t next_st;

	logic bit_ev;
	logic start_ev;
	logic stop_ev;
	logic bit_lvl;

	// ==========================================================
	// crossing: toggles pass two flops before edge detection
	assign bit_ev = st.bit_s[2] ^ st.bit_s[1];
	assign start_ev = st.start_s[2] ^ st.start_s[1];
	assign stop_ev = st.stop_s[2] ^ st.stop_s[1];
	// level read in the same cycle as its toggle, both settled through two flops
	assign bit_lvl = st.val_s[1];

	function automatic logic mid_frame(input logic [3:0] cnt);
		mid_frame = (cnt != 4'h0);
	endfunction

	// own address seen and answering enabled
	function automatic logic own_hit(input logic [7:0] shift,
		input logic [6:0] addr, input logic ack_en);
		own_hit = ack_en && (shift[6:0] == addr);
	endfunction

	// ==========================================================
	// protocol and status
	always_comb
	begin
		next_st = st;
		next_st.bit_s = {st.bit_s[1:0], bit_tgl};
		next_st.start_s = {st.start_s[1:0], start_tgl};
		next_st.stop_s = {st.stop_s[1:0], stop_tgl};
		next_st.val_s = {st.val_s[0], bit_val};
		// the enum has only legal codes; the default branch below takes the idle and waiting modes
		if ((start_ev || stop_ev) && mid_frame(st.bit_cnt)
			&& st.mode != twsea_pkg::TWSEA_IDLE)
		begin
			next_st.flag = 1'b1; // see [RULE4]
			next_st.status = twsea_pkg::ST_BUS_ERROR; // see [RULE2] see [RULE3]
			next_st.mode = twsea_pkg::TWSEA_WAIT_SW;
			next_st.drive_low = 1'b0;
			next_st.bit_cnt = 4'h0;
		end
		else if (start_ev)
		begin
			next_st.bit_cnt = 4'h0;
			next_st.in_addr = 1'b1;
			next_st.lost = 1'b0;
			// repeated start by the owner keeps the bus
			if (st.owner)
				next_st.mode = twsea_pkg::TWSEA_MASTER; // see [RULE9]
			else if (st.mode == twsea_pkg::TWSEA_IDLE && ctrl.start_req)
			begin
				// free bus and a request: contend from this start on
				next_st.mode = twsea_pkg::TWSEA_MASTER;
				next_st.owner = 1'b1;
			end
			else
				next_st.mode = twsea_pkg::TWSEA_SLAVE_ADDR;
		end
		else if (stop_ev)
		begin
			next_st.bit_cnt = 4'h0;
			next_st.owner = 1'b0;
			if (st.mode == twsea_pkg::TWSEA_WAIT_FREE)
			begin
				next_st.mode = twsea_pkg::TWSEA_MASTER;
				next_st.owner = 1'b1;
				next_st.pend_start = 1'b0;
			end
			else if (st.mode != twsea_pkg::TWSEA_WAIT_SW)
				next_st.mode = twsea_pkg::TWSEA_IDLE;
		end
		else if (bit_ev)
		begin
			next_st.shift = {st.shift[6:0], bit_lvl};
			next_st.bit_cnt = st.bit_cnt + 4'h1;
			unique case (st.mode)
				twsea_pkg::TWSEA_MASTER:
				begin
					// equal levels mean no contention is seen
					if (tx_bit_req && tx_bit && !bit_lvl
						&& !st.lost) // see [RULE11] see [RULE18]
					begin
						next_st.lost = 1'b1; // see [RULE12]
						next_st.drive_low = 1'b0; // see [RULE19]
						next_st.owner = 1'b0;
						next_st.mode = st.in_addr
							? twsea_pkg::TWSEA_SLAVE_ADDR // see [RULE14]
							: twsea_pkg::TWSEA_WAIT_SW; // see [RULE13]
						if (!st.in_addr)
						begin
							next_st.flag = 1'b1;
							next_st.status = twsea_pkg::ST_ARB_LOST;
						end
					end
					// the eighth bit carries the direction, not the address
					if (st.bit_cnt == 4'h6)
						next_st.in_addr = 1'b0;
				end
				twsea_pkg::TWSEA_SLAVE_ADDR:
				begin
					if (st.bit_cnt == 4'h7)
					begin
						next_st.in_addr = 1'b0;
						if (own_hit(st.shift, own_addr, ctrl.ack_en))
						begin // see [RULE17]
							next_st.flag = 1'b1;
							next_st.mode = twsea_pkg::TWSEA_WAIT_SW;
							next_st.status = bit_lvl
								? twsea_pkg::ST_ARB_LOST_ST
								: twsea_pkg::ST_ARB_LOST_SR; // see [RULE15]
						end
						else if (st.lost)
						begin
							next_st.flag = 1'b1; // see [RULE16]
							next_st.mode = twsea_pkg::TWSEA_WAIT_SW;
							next_st.status = twsea_pkg::ST_ARB_LOST;
						end
						else
							next_st.mode = twsea_pkg::TWSEA_IDLE;
					end
				end
				default:
				begin
					// idle or waiting: only monitor
				end
			endcase
			if (st.bit_cnt == twsea_pkg::BIT_COUNT_LAST)
				next_st.bit_cnt = 4'h0;
		end
		// software write of a set flag (clear beats a set above)
		if (ctrl.done_write && st.flag && !next_st.flag == 1'b0
			&& st.flag == next_st.flag)
		begin
			next_st.flag = 1'b0;
			next_st.stop_rq = ctrl.stop_req;
			if (st.status == twsea_pkg::ST_BUS_ERROR && ctrl.stop_req)
			begin
				next_st.mode = twsea_pkg::TWSEA_IDLE; // see [RULE6]
				next_st.stop_rq = 1'b0; // see [RULE6]
				next_st.drive_low = 1'b0; // see [RULE7]
				next_st.owner = 1'b0; // see [RULE7]
				next_st.lost = 1'b0;
			end
			else if (st.mode == twsea_pkg::TWSEA_WAIT_SW)
			begin
				next_st.lost = 1'b0;
				next_st.mode = ctrl.start_req
					? twsea_pkg::TWSEA_WAIT_FREE
					: twsea_pkg::TWSEA_IDLE; // see [RULE13] see [RULE16]
				next_st.pend_start = ctrl.start_req;
			end
		end
		// pull sda low only while contending and sending a zero
		next_st.drive_low = next_st.mode == twsea_pkg::TWSEA_MASTER
			&& !next_st.lost && tx_bit_req && !tx_bit; // see [RULE19]
		if (!next_st.flag)
			next_st.status = twsea_pkg::ST_NO_INFO; // see [RULE1] see [RULE8]
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.mode <= twsea_pkg::TWSEA_IDLE;
			st.status <= twsea_pkg::ST_NO_INFO;
		end
		else if (clk_en)
			st <= next_st;
	end

	// ==========================================================
	// outputs (registered state; sda_out and scl_oe_n are constant)
	assign sda_out = 1'b0;
	assign sda_oe_n = ~st.drive_low;
	assign scl_oe_n = 1'b1;
	assign transfer_done_flag = st.flag;
	assign stop_request_bit = st.stop_rq;
	assign bus_status_register = st.status;
	assign in_master = st.owner;
	assign start_pending = st.pend_start;

	// ==========================================================
	// checks
	status_noinfo_a: assert property (@(posedge clock) disable iff (!rst_n)
		!transfer_done_flag |-> bus_status_register == 8'hF8) // see [RULE1]
		else $error("status not no-info while flag clear");
	err_sets_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && (start_ev || stop_ev) && st.bit_cnt != 4'h0
		&& st.mode != twsea_pkg::TWSEA_IDLE
		|=> transfer_done_flag && bus_status_register == 8'h00)
		else $error("bus error not flagged"); // see [RULE4]
	recover_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && transfer_done_flag && bus_status_register == 8'h00
		&& ctrl.done_write && ctrl.stop_req && !start_ev && !stop_ev
		|=> !stop_request_bit && sda_oe_n && !in_master)
		else $error("recovery did not release"); // see [RULE6]
	release_scl_a: assert property (@(posedge clock) disable iff (!rst_n)
		scl_oe_n) else $error("scl driven"); // see [RULE7]
	lost_release_a: assert property (@(posedge clock) disable iff (!rst_n)
		st.lost |-> sda_oe_n) else $error("sda driven after loss"); // see [RULE19]
	lose_arb_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && bit_ev && !start_ev && !stop_ev
		&& st.mode == twsea_pkg::TWSEA_MASTER
		&& tx_bit_req && tx_bit && !bit_lvl && !st.lost
		|=> st.lost && !in_master) else $error("loss missed"); // see [RULE12]
	rep_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && start_ev && !stop_ev && in_master && st.bit_cnt == 4'h0
		|=> in_master) else $error("owner dropped on restart"); // see [RULE9]
	ack_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl.ack_en && !st.lost && st.mode == twsea_pkg::TWSEA_SLAVE_ADDR
		&& !transfer_done_flag ##1 !ctrl.ack_en |-> !transfer_done_flag
		|| bus_status_register == 8'h00) else $error("addressed w/o ack"); // see [RULE17]

	// ==========================================================
	// arbitration and flag checks
	drive_owner_a: assert property ( // see [RULE19]
		@(posedge clock) disable iff (!rst_n)
		!sda_oe_n |-> in_master && !st.lost)
		else $error("sda driven while not owning the bus");
	flag_stands_a: assert property ( // see [RULE4]
		@(posedge clock) disable iff (!rst_n)
		transfer_done_flag && !ctrl.done_write |=> transfer_done_flag)
		else $error("flag dropped without a write");
	noflag_write_a: assert property ( // see [RULE8]
		@(posedge clock) disable iff (!rst_n)
		!transfer_done_flag |=> stop_request_bit == $past(stop_request_bit))
		else $error("control changed while flag clear");
	addr_loss_a: assert property ( // see [RULE14]
		@(posedge clock) disable iff (!rst_n)
		clk_en && bit_ev && !start_ev && !stop_ev && !transfer_done_flag
		&& st.mode == twsea_pkg::TWSEA_MASTER && st.in_addr && !st.lost
		&& tx_bit_req && tx_bit && !bit_lvl
		|=> st.mode == twsea_pkg::TWSEA_SLAVE_ADDR && !transfer_done_flag)
		else $error("address loss did not switch to slave");
	data_loss_a: assert property ( // see [RULE13]
		@(posedge clock) disable iff (!rst_n)
		clk_en && bit_ev && !start_ev && !stop_ev && !transfer_done_flag
		&& st.mode == twsea_pkg::TWSEA_MASTER && !st.in_addr && !st.lost
		&& tx_bit_req && tx_bit && !bit_lvl
		|=> transfer_done_flag
		&& bus_status_register == twsea_pkg::ST_ARB_LOST)
		else $error("data loss not flagged");
	addr_hit_a: assert property ( // see [RULE15]
		@(posedge clock) disable iff (!rst_n)
		clk_en && bit_ev && !start_ev && !stop_ev && !transfer_done_flag
		&& st.mode == twsea_pkg::TWSEA_SLAVE_ADDR && st.bit_cnt == 4'h7
		&& own_hit(st.shift, own_addr, ctrl.ack_en)
		|=> transfer_done_flag && bus_status_register == ($past(bit_lvl)
		? twsea_pkg::ST_ARB_LOST_ST : twsea_pkg::ST_ARB_LOST_SR))
		else $error("own address not taken");
	not_addr_a: assert property ( // see [RULE16]
		@(posedge clock) disable iff (!rst_n)
		clk_en && bit_ev && !start_ev && !stop_ev && !transfer_done_flag
		&& st.mode == twsea_pkg::TWSEA_SLAVE_ADDR && st.bit_cnt == 4'h7
		&& st.lost && !own_hit(st.shift, own_addr, ctrl.ack_en)
		|=> transfer_done_flag
		&& bus_status_register == twsea_pkg::ST_ARB_LOST)
		else $error("unaddressed loser not flagged");
	wait_exit_a: assert property ( // see [RULE13]
		@(posedge clock) disable iff (!rst_n)
		clk_en && transfer_done_flag && ctrl.done_write && !ctrl.stop_req
		&& !start_ev && !stop_ev && st.mode == twsea_pkg::TWSEA_WAIT_SW
		|=> !transfer_done_flag && start_pending == $past(ctrl.start_req))
		else $error("software response not taken");
	cov_restart_c: cover property (@(posedge clock)
		start_ev && in_master);
	cov_err_c: cover property (@(posedge clock)
		bus_status_register == 8'h00);
	cov_lost_c: cover property (@(posedge clock) st.lost);
	cov_sr_c: cover property (@(posedge clock)
		bus_status_register == twsea_pkg::ST_ARB_LOST_SR);

endmodule
`default_nettype wire

// [design/twsea_link.sv]
`timescale 1ns/100ps
`default_nettype none
// link-clock side: compares sda at the rise and at the fall of scl and
// reports bit levels and start/stop conditions by toggles
module twsea_link
(
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic sda_in,
	output logic bit_tgl,
	output logic bit_val,
	output logic start_tgl,
	output logic stop_tgl
);

	typedef struct packed {
		logic bit_tgl;
		logic bit_val;
		logic start_tgl;
		logic stop_tgl;
	} twsea_link_st_t;

	twsea_link_st_t st;
	twsea_link_st_t next_st;
	logic rise_lvl;

	// ==========================================================
	// data may only move while scl is low, so a level change between the
	// rise and the fall of scl can only be a start or a stop
	always_comb
	begin
		next_st = st;
		if (rise_lvl && !sda_in)
			next_st.start_tgl = ~st.start_tgl;
		else if (!rise_lvl && sda_in)
			next_st.stop_tgl = ~st.stop_tgl;
		else
		begin
			next_st.bit_tgl = ~st.bit_tgl;
			next_st.bit_val = rise_lvl;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			rise_lvl <= 1'b1;
		else
			rise_lvl <= sda_in;
	end

	always_ff @(negedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign bit_tgl = st.bit_tgl;
	assign bit_val = st.bit_val;
	assign start_tgl = st.start_tgl;
	assign stop_tgl = st.stop_tgl;

endmodule
`default_nettype wire

// [design/twsea_pkg.sv]
package twsea_pkg;

	// status codes (prescaler bits zero)
	localparam logic [7:0] ST_NO_INFO = 8'hF8;
	localparam logic [7:0] ST_BUS_ERROR = 8'h00;
	localparam logic [7:0] ST_ARB_LOST = 8'h38;
	localparam logic [7:0] ST_ARB_LOST_SR = 8'h68;
	localparam logic [7:0] ST_ARB_LOST_ST = 8'hB0;
	localparam logic [7:0] ST_ADDR_IDLE = 8'hF8;

	// reset value and last bit count
	localparam logic [6:0] OWN_ADDR_RST = 7'h00;
	localparam logic [3:0] BIT_COUNT_LAST = 4'h8;

	typedef enum {TWSEA_IDLE, TWSEA_MASTER, TWSEA_SLAVE_ADDR, TWSEA_WAIT_SW,
		TWSEA_WAIT_FREE} twsea_mode_t;

	// software control word
	typedef struct packed {
		logic start_req;
		logic stop_req;
		logic ack_en;
		logic done_write;
	} twsea_ctrl_t;

	// link-side events handed to the system clock domain
	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic mid_frame;
	} twsea_line_t;

endpackage

// [tb/two_wire_status_error_arbitration_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module two_wire_status_error_arbitration_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic tx_bit_req = 1'b0;
	logic tx_bit = 1'b0;
	logic link_clk, sda, sda_out, sda_oe_n, scl_oe_n, flag, stop_bit;
	logic in_master, start_pending;
	logic [7:0] status;
	twsea_pkg::twsea_ctrl_t ctrl = '0;
	int num_errors = 0;
	int n_compared = 0;
	typedef struct {logic ack; logic stop; logic dw;} twsea_row_t;
	twsea_row_t rows [4] = '{'{0, 0, 1}, '{1, 0, 1}, '{0, 1, 0}, '{1, 1, 1}};
	always #5 clock = ~clock;
	twsea_bus_model u_bus (.dut_oe_n(sda_oe_n), .scl(link_clk), .sda(sda));
	twsea_core u_dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
		.link_clk(link_clk), .sda_in(sda), .own_addr(7'h2A),
		.ctrl(ctrl), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n),
		.transfer_done_flag(flag), .stop_request_bit(stop_bit),
		.bus_status_register(status), .in_master(in_master),
		.start_pending(start_pending));
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_flag();
		for (int i = 0; i < 300 && flag !== 1'b1; i++)
			@(negedge clock);
		check("done flag", {7'h00, flag}, 8'h01);
	endtask
	// software response: one write of the flag plus level bits
	task automatic sw_write(input logic sta, input logic sto, input logic ack);
		@(negedge clock);
		ctrl = '{sta, sto, ack, 1'b1};
		@(negedge clock);
		ctrl.done_write = 1'b0;
		ctrl.stop_req = 1'b0;
		ctrl.start_req = 1'b0;
	endtask
	// one bit: the block's own value held over the bit, the line's value
	task automatic tx_put(input logic tx, input logic line);
		@(negedge clock);
		tx_bit = tx;
		@(negedge clock);
		u_bus.put_bit(line);
		repeat (5) @(negedge clock);
	endtask
	task automatic bus_error_case(input logic ack);
		u_bus.put_start();
		repeat (3) u_bus.put_bit(1'b0);
		u_bus.put_start();
		wait_flag();
		check("error status", status, twsea_pkg::ST_BUS_ERROR);
		sw_write(1'b0, 1'b1, ack);
		check("flag after recovery", {7'h00, flag}, 8'h00);
		check("stop bit", {7'h00, stop_bit}, 8'h00);
		check("status", status, twsea_pkg::ST_NO_INFO);
		check("sda released", {7'h00, sda_oe_n}, 8'h01);
		check("scl released", {7'h00, scl_oe_n}, 8'h01);
		repeat (20) @(negedge clock);
		check("no stop sent", {7'h00, link_clk}, 8'h00);
	endtask
	task automatic report_and_stop();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		// ====================
		// idle: writes of the flag while it is clear change nothing
		foreach (rows[i])
		begin
			@(negedge clock);
			ctrl = '{1'b0, rows[i].stop, rows[i].ack, rows[i].dw};
			@(negedge clock);
			ctrl = '0;
			repeat (2) @(negedge clock);
			check("idle flag", {7'h00, flag}, 8'h00);
			check("idle status", status, twsea_pkg::ST_NO_INFO);
		end
		// ====================
		// bus error, recovery with either acknowledge setting
		bus_error_case(1'b0);
		bus_error_case(1'b1);
		// ====================
		// arbitration: matching bits pass, a repeated start keeps the bus,
		// a one against a zero in the address loses
		@(negedge clock);
		ctrl.start_req = 1'b1;
		u_bus.put_start();
		tx_bit_req = 1'b1;
		for (int b = 0; b < 9; b++)
			tx_put(b[0], b[0]);
		check("no contention", {7'h00, flag}, 8'h00);
		check("owner", {7'h00, in_master}, 8'h01);
		@(negedge clock);
		tx_bit_req = 1'b0;
		@(negedge clock);
		u_bus.put_start();
		repeat (6) @(negedge clock);
		check("owner after restart", {7'h00, in_master}, 8'h01);
		check("restart no error", {7'h00, flag}, 8'h00);
		tx_bit_req = 1'b1;
		for (int b = 0; b < 3; b++)
			tx_put(b[0], b[0]);
		tx_put(1'b1, 1'b0);
		check("lost owner", {7'h00, in_master}, 8'h00);
		check("lost no flag", {7'h00, flag}, 8'h00);
		tx_put(1'b0, 1'b0);
		check("sda let go", {7'h00, sda_oe_n}, 8'h01);
		tx_bit_req = 1'b0;
		repeat (3) u_bus.put_bit(1'b0);
		wait_flag();
		check("lost code", status, twsea_pkg::ST_ARB_LOST);
		sw_write(1'b0, 1'b0, 1'b1);
		check("slave mode flag", {7'h00, flag}, 8'h00);
		check("slave mode status", status, twsea_pkg::ST_NO_INFO);
		check("no start pending", {7'h00, start_pending}, 8'h00);
		// ====================
		// loss in the first address bit, then addressed as a receiver
		@(negedge clock);
		ctrl.start_req = 1'b1;
		u_bus.put_start();
		tx_bit_req = 1'b1;
		tx_put(1'b1, 1'b0);
		tx_bit_req = 1'b0;
		for (int b = 1; b < 7; b++)
			u_bus.put_bit(b[0]);
		u_bus.put_bit(1'b0);
		wait_flag();
		check("addressed code", status, twsea_pkg::ST_ARB_LOST_SR);
		sw_write(1'b0, 1'b0, 1'b1);
		// ====================
		// loss in a data bit, then wait for a free bus
		@(negedge clock);
		ctrl.start_req = 1'b1;
		u_bus.put_start();
		tx_bit_req = 1'b1;
		for (int b = 0; b < 9; b++)
			tx_put(b[0], b[0]);
		tx_put(1'b1, 1'b0);
		tx_bit_req = 1'b0;
		wait_flag();
		check("data loss code", status, twsea_pkg::ST_ARB_LOST);
		sw_write(1'b1, 1'b0, 1'b1);
		check("start pending", {7'h00, start_pending}, 8'h01);
		repeat (8) u_bus.put_bit(1'b0);
		u_bus.put_stop();
		repeat (6) @(negedge clock);
		check("master after stop", {7'h00, in_master}, 8'h01);
		check("pending taken", {7'h00, start_pending}, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire

// [tb/twsea_bus_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// far-side master
// scl only moves inside frames; sda is open-drain with a pull-up
module twsea_bus_model
(
	input wire logic dut_oe_n,
	output logic scl,
	output logic sda
);
	logic drv = 1'b1;
	// wired-and of both parties, released lines read high
	assign sda = drv & dut_oe_n;
	initial scl = 1'b1;
	// data changes only while scl is low
	task automatic put_bit(input logic v);
		scl = 1'b0;
		// data moves a little after the fall, never with it
		#2;
		drv = v;
		#6;
		scl = 1'b1;
		#15;
		scl = 1'b0;
		#7;
	endtask
	// a start in mid-byte is how the bench makes a bus error
	task automatic put_start();
		drv = 1'b1;
		#5;
		scl = 1'b1;
		#10;
		drv = 1'b0;
		#10;
		scl = 1'b0;
		#5;
	endtask
	// stop: sda rises while scl is high
	task automatic put_stop();
		drv = 1'b0;
		#5;
		scl = 1'b1;
		#10;
		drv = 1'b1;
		#10;
		scl = 1'b0;
		#5;
	endtask
endmodule
`default_nettype wire
